// ===== design/bao_pkg.sv
// Constants and types of the bypass attribute override block
// ----------------------------------------------------------
// ----------------------------------------------------------
package bao_pkg;
  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] ADR_NS_CTRL = 8'h00;
  localparam logic [7:0] ADR_S_CTRL = 8'h04;
  localparam logic [7:0] ADR_NS_BYP = 8'h08;
  localparam logic [7:0] ADR_S_BYP = 8'h0c;
  localparam logic [7:0] ADR_CAP3 = 8'h10;
  localparam logic [7:0] ADR_SCAP1 = 8'h14;
  localparam logic [7:0] ADR_STATUS = 8'h18;
  localparam logic [7:0] ADR_XREQ = 8'h1c;
  localparam logic [7:0] ADR_XRES = 8'h20;
  // Stream table window starts here, one word per entry
  localparam int ADR_STE_BIT = 7;
  // ----------------------------------------------------------
  // Field positions of bypass registers, stream entries, control, capability and probe words
  // ----------------------------------------------------------
  localparam int F_MT = 0;
  localparam int F_MEMORY_TYPE_OVERRIDE_SEL = 5;
  localparam int F_AL = 8;
  localparam int F_ALOVR = 11;
  localparam int F_SH = 12;
  localparam int F_INST = 16;
  localparam int F_PRIV = 18;
  localparam int F_NS = 20;
  localparam int F_CFG = 24;
  localparam int F_FWB = 28;
  localparam int F_FEN = 0;
  localparam int F_CAP_FWB = 8;
  localparam int F_CAP_SEC = 31;
  localparam int F_XVLD = 31;
  localparam int F_XPATH = 24;
  // Supplied-attribute mask positions
  localparam int SUP_MT = 0;
  localparam int SUP_SH = 1;
  localparam int SUP_AL = 2;
  localparam int SUP_INST = 3;
  localparam int SUP_PRIV = 4;
  localparam int SUP_NS = 5;
  // ----------------------------------------------------------
  // Encodings and build-time values
  // ----------------------------------------------------------
  localparam logic [1:0] C_NC = 2'h0;
  localparam logic [1:0] SH_NSH = 2'h0;
  localparam logic [1:0] SH_INC = 2'h1;
  localparam logic [1:0] SH_OSH = 2'h2;
  localparam logic [1:0] SH_ISH = 2'h3;
  localparam logic [4:0] MT_NORMAL_WB = 5'h1f;
  localparam logic [5:0] HINT_DFLT = 6'h36;
  localparam logic [2:0] CFG_BYPASS = 3'h4;
  localparam int CFG_S2 = 1;
  localparam logic [31:0] NS_BYP_RST = 32'h0000_1000;
  localparam logic [31:0] S_BYP_RST = 32'h0000_1000;
  localparam logic CAP_FWB = 1'b1;
  localparam logic CAP_SEC = 1'b1;
  localparam int STE_N = 32;

  typedef struct packed {
    logic [4:0] mt;
    logic [1:0] sh;
    logic i_ra, i_wa, i_tr, o_ra, o_wa, o_tr;
    logic inst, priv, ns;
  } bao_attr_t;

  typedef struct packed {
    logic [31:0] addr;
    logic we;
    logic [31:0] data;
    logic [3:0] stream_identifier;
    logic secure_stream_flag;
    logic no_snoop;
    logic [5:0] supplied;
    bao_attr_t attr;
  } bao_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic we;
    logic [31:0] data;
    logic abort;
    bao_attr_t attr;
  } bao_rsp_t;

  typedef enum logic [2:0] {
    PATH_NS_GBP = 3'b000,
    PATH_S_GBP = 3'b001,
    PATH_STE_BYP = 3'b010,
    PATH_XLAT = 3'b011,
    PATH_ABORT = 3'b100
  } bao_path_t;
endpackage : bao_pkg

// ===== design/bao_top.sv
// Attribute override and consistency stage with register slave
`timescale 1ns/10ps
module bao_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic in_valid_i,
  input wire bao_pkg::bao_req_t in_req_i,
  output logic out_valid_o,
  output bao_pkg::bao_rsp_t out_rsp_o,
  output bao_pkg::bao_path_t out_path_o
);
  import bao_pkg::*;

  // ----------------------------------------------------------
  // Register state
  // ----------------------------------------------------------
  logic nonsecure_control_reg;
  logic secure_control_reg;
  logic [31:0] nonsecure_bypass_attr_reg;
  logic [31:0] secure_bypass_attr_reg;
  logic [31:0] xlat_result;
  logic [15:0] txn_count;
  logic [31:0] ste_table [0:STE_N-1];

  // ----------------------------------------------------------
  // Attribute functions
  // ----------------------------------------------------------
  // Fill in what the interconnect could not carry
  function automatic bao_attr_t add_defaults(bao_attr_t a, logic [5:0] s);
    bao_attr_t r;
    r = a;
    if (!s[SUP_MT]) r.mt = MT_NORMAL_WB;
    if (!s[SUP_SH]) r.sh = SH_NSH;
    if (!s[SUP_AL]) {r.i_ra, r.i_wa, r.i_tr, r.o_ra, r.o_wa, r.o_tr} = HINT_DFLT;
    if (!s[SUP_INST]) r.inst = 1'b0;
    if (!s[SUP_PRIV]) r.priv = 1'b0;
    if (!s[SUP_NS]) r.ns = 1'b1;
    return r;
  endfunction : add_defaults

  // Any level cacheable
  function automatic logic cacheable(logic [4:0] mt);
    return mt[4] && (mt[3:0] != 4'h0);
  endfunction : cacheable

  // Per-field replace; a clear select keeps the incoming value, save hints reset by a type override and ns forced high off the secure side
  function automatic bao_attr_t replace_attrs(bao_attr_t a, logic [31:0] c, logic sec);
    bao_attr_t r;
    r = a;
    if (c[F_MEMORY_TYPE_OVERRIDE_SEL]) begin
      r.mt = c[F_MT +: 5];
      // New cacheable type from a non-cacheable input gets allocate hints
      if (!cacheable(a.mt) && !c[F_ALOVR])
        {r.i_ra, r.i_wa, r.i_tr, r.o_ra, r.o_wa, r.o_tr} = HINT_DFLT;
    end
    if (c[F_ALOVR]) begin
      // One override drives both cache levels
      {r.i_ra, r.i_wa, r.i_tr} = c[F_AL +: 3];
      {r.o_ra, r.o_wa, r.o_tr} = c[F_AL +: 3];
    end
    if (c[F_SH +: 2] != SH_INC) r.sh = c[F_SH +: 2];
    if (c[F_INST + 1]) r.inst = c[F_INST];
    if (c[F_PRIV + 1]) r.priv = c[F_PRIV];
    if (c[F_NS + 1]) r.ns = c[F_NS];
    if (!sec) r.ns = 1'b1;
    return r;
  endfunction : replace_attrs

  // Remove combinations the memory system must never see
  function automatic bao_attr_t make_consistent(bao_attr_t a);
    bao_attr_t r;
    r = a;
    if (!cacheable(a.mt)) r.sh = SH_OSH;
    if (!a.mt[4] || a.mt[1:0] == C_NC)
      {r.i_ra, r.i_wa, r.i_tr} = 3'h0;
    else if (!a.i_ra && !a.i_wa)
      r.i_tr = 1'b0;
    if (!a.mt[4] || a.mt[3:2] == C_NC)
      {r.o_ra, r.o_wa, r.o_tr} = 3'h0;
    else if (!a.o_ra && !a.o_wa)
      r.o_tr = 1'b0;
    return r;
  endfunction : make_consistent

  // Stage-2 forced write-back: Normal WB, at least inner shareable
  function automatic bao_attr_t force_wb(bao_attr_t a);
    bao_attr_t r;
    r = a;
    r.mt = MT_NORMAL_WB;
    if (a.sh == SH_NSH) r.sh = SH_ISH;
    if (!cacheable(a.mt))
      {r.i_ra, r.i_wa, r.i_tr, r.o_ra, r.o_wa, r.o_tr} = HINT_DFLT;
    return r;
  endfunction : force_wb

  // Pick the handling of one transaction
  function automatic bao_path_t route(logic sec, logic [31:0] ste, logic ns_en, logic s_en);
    bao_path_t p;
    if (sec) p = s_en ? PATH_XLAT : PATH_S_GBP;
    else p = ns_en ? PATH_XLAT : PATH_NS_GBP;
    if (p == PATH_XLAT) begin
      if (ste[F_CFG +: 3] == CFG_BYPASS) p = PATH_STE_BYP;
      else if (!ste[F_CFG + 2]) p = PATH_ABORT;
    end
    return p;
  endfunction : route

  // Full attribute result for a path
  function automatic bao_attr_t resolve(bao_attr_t a, bao_path_t p, logic sec, logic nsnp,
                                        logic [31:0] ste, logic [31:0] nsb, logic [31:0] sb);
    bao_attr_t r;
    r = a;
    unique case (p)
      PATH_NS_GBP: r = replace_attrs(a, nsb, 1'b0);
      PATH_S_GBP: r = replace_attrs(a, sb, 1'b1);
      PATH_STE_BYP: r = replace_attrs(a, ste, sec);
      PATH_XLAT: begin
        r = replace_attrs(a, ste, sec);
        // Stand-in for the stage-2 combine: only the forced write-back term
        if (CAP_FWB && ste[F_FWB] && ste[F_CFG + CFG_S2] && !nsnp)
          r = force_wb(r);
      end
      PATH_ABORT: r = a;
    endcase
    return make_consistent(r);
  endfunction : resolve

  // Byte-lane write merge
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    return r;
  endfunction : merge

  // ----------------------------------------------------------
  // Transaction datapath
  // ----------------------------------------------------------
  // Secure flag means nothing without the security extension
  wire txn_sec = in_req_i.secure_stream_flag & CAP_SEC;
  wire [4:0] txn_idx = {txn_sec, in_req_i.stream_identifier};
  // Forced write-back enable lives in the entry, so it follows the VM
  wire [31:0] txn_ste = ste_table[txn_idx];
  wire bao_attr_t txn_in = add_defaults(in_req_i.attr, in_req_i.supplied);
  wire bao_path_t txn_path = route(txn_sec, txn_ste, nonsecure_control_reg, secure_control_reg);
  wire bao_attr_t txn_attr = resolve(txn_in, txn_path, txn_sec, in_req_i.no_snoop, txn_ste,
                                     nonsecure_bypass_attr_reg, secure_bypass_attr_reg);

  // Payload fields copied untouched
  wire bao_rsp_t next_rsp = '{addr: in_req_i.addr, we: in_req_i.we, data: in_req_i.data,
                              abort: (txn_path == PATH_ABORT), attr: txn_attr};

  // ----------------------------------------------------------
  // Software translation request
  // ----------------------------------------------------------
  // Probe uses constructed defaults, as no interconnect attributes exist
  wire [4:0] sw_idx = {wb_dat_i[4] & CAP_SEC, wb_dat_i[3:0]};
  wire [31:0] sw_ste = ste_table[sw_idx];
  wire bao_path_t sw_path = route(sw_idx[4], sw_ste, nonsecure_control_reg, secure_control_reg);
  wire bao_attr_t sw_attr = resolve(add_defaults('0, 6'h00), sw_path, sw_idx[4], 1'b0, sw_ste,
                                    nonsecure_bypass_attr_reg, secure_bypass_attr_reg);

  // ----------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire ste_hit = wb_adr_i[ADR_STE_BIT];
  wire [4:0] ste_idx = wb_adr_i[ADR_STE_BIT-1:2];
  wire sw_go = wb_wr && !ste_hit && wb_adr_i == ADR_XREQ && wb_sel_i[0];
  wire [31:0] cap3_word = {23'h0, CAP_FWB, 8'h00};
  wire [31:0] scap1_word = {CAP_SEC, 31'h0};
  wire [31:0] stat_word = {13'h0, out_path_o, txn_count};
  logic [31:0] rd_mux;

  // Read select; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ste_hit) rd_mux = ste_table[ste_idx];
    else begin
      unique case (wb_adr_i)
        ADR_NS_CTRL: rd_mux = {31'h0, nonsecure_control_reg};
        ADR_S_CTRL: rd_mux = {31'h0, secure_control_reg};
        ADR_NS_BYP: rd_mux = nonsecure_bypass_attr_reg;
        ADR_S_BYP: rd_mux = CAP_SEC ? secure_bypass_attr_reg : 32'h0;
        ADR_CAP3: rd_mux = cap3_word;
        ADR_SCAP1: rd_mux = scap1_word;
        ADR_STATUS: rd_mux = stat_word;
        ADR_XRES: rd_mux = xlat_result;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------
  // Bus slave registers
  // ----------------------------------------------------------
  // Ack one cycle after the request, then drop; writes land at that edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= rd_mux;
    end
  end

  // Control and bypass registers; resets chosen at build time
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      nonsecure_control_reg <= 1'b0;
      secure_control_reg <= 1'b0;
      nonsecure_bypass_attr_reg <= NS_BYP_RST;
      secure_bypass_attr_reg <= S_BYP_RST;
    end else if (ce_i && wb_wr && !ste_hit) begin
      if (wb_adr_i == ADR_NS_CTRL && wb_sel_i[0]) nonsecure_control_reg <= wb_dat_i[F_FEN];
      if (wb_adr_i == ADR_S_CTRL && wb_sel_i[0]) secure_control_reg <= wb_dat_i[F_FEN] & CAP_SEC;
      if (wb_adr_i == ADR_NS_BYP)
        nonsecure_bypass_attr_reg <= merge(nonsecure_bypass_attr_reg, wb_dat_i, wb_sel_i);
      if (wb_adr_i == ADR_S_BYP && CAP_SEC)
        secure_bypass_attr_reg <= merge(secure_bypass_attr_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Stream table; reset to abort so stray streams go nowhere
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < STE_N; i++) ste_table[i] <= 32'h0000_0000;
    end else if (ce_i && wb_wr && ste_hit) begin
      ste_table[ste_idx] <= merge(ste_table[ste_idx], wb_dat_i, wb_sel_i);
    end
  end

  // Probe result; a new request replaces the old one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) xlat_result <= 32'h0000_0000;
    else if (ce_i && sw_go) xlat_result <= {1'b1, 4'h0, sw_path, 8'h00, sw_attr};
  end

  // ----------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------
  // One register stage; the interconnect takes every beat
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      out_valid_o <= 1'b0;
      out_rsp_o <= '0;
      out_path_o <= PATH_NS_GBP;
      txn_count <= 16'h0000;
    end else if (ce_i) begin
      out_valid_o <= in_valid_i;
      if (in_valid_i) begin
        out_rsp_o <= next_rsp;
        out_path_o <= txn_path;
        txn_count <= txn_count + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Beat timing and payload
  a_beat_passes: assert property (ce_i && in_valid_i |=> out_valid_o
    && out_rsp_o.addr == $past(in_req_i.addr) && out_rsp_o.data == $past(in_req_i.data)
    && out_rsp_o.we == $past(in_req_i.we))
    else $error("payload changed in bypass");

  // Path selection
  a_disabled_path: assert property (ce_i && in_valid_i && !txn_sec && !nonsecure_control_reg
    |=> out_path_o == PATH_NS_GBP)
    else $error("disabled non-secure stream not in global bypass");

  a_secure_path: assert property (ce_i && in_valid_i && txn_sec && !secure_control_reg
    |=> out_path_o == PATH_S_GBP)
    else $error("disabled secure stream not in secure bypass");

  // Security attribute on the bypass paths
  a_gbp_ns_one: assert property (out_valid_o && out_path_o == PATH_NS_GBP |-> out_rsp_o.attr.ns)
    else $error("non-secure bypass output secure");

  a_ste_ns_one: assert property (ce_i && in_valid_i && txn_path == PATH_STE_BYP && !txn_sec
    |=> out_rsp_o.attr.ns)
    else $error("non-secure entry bypass output secure");

  // Consistency of what reaches the interconnect
  a_nc_outer_sh: assert property (out_valid_o && !cacheable(out_rsp_o.attr.mt)
    |-> out_rsp_o.attr.sh == SH_OSH)
    else $error("non-cacheable output not outer shareable");

  a_nc_no_hints: assert property (out_valid_o && (!out_rsp_o.attr.mt[4]
    || out_rsp_o.attr.mt[1:0] == C_NC) |-> !(out_rsp_o.attr.i_ra | out_rsp_o.attr.i_wa | out_rsp_o.attr.i_tr))
    else $error("hints on non-cacheable inner level");

  a_noalloc_ntr: assert property (out_valid_o && out_rsp_o.attr.mt[4]
    && !out_rsp_o.attr.o_ra && !out_rsp_o.attr.o_wa |-> !out_rsp_o.attr.o_tr)
    else $error("transient on no-allocate outer level");

  // Forced write-back and the probe
  a_fwb_forces: assert property (ce_i && in_valid_i && txn_path == PATH_XLAT && CAP_FWB
    && txn_ste[F_FWB] && txn_ste[F_CFG + CFG_S2] && !in_req_i.no_snoop
    |=> out_rsp_o.attr.mt == MT_NORMAL_WB && out_rsp_o.attr.sh != SH_NSH)
    else $error("forced write-back not applied");

  a_probe_done: assert property (ce_i && sw_go |=> xlat_result[F_XVLD]
    && xlat_result[F_XPATH +: 3] == $past(sw_path))
    else $error("probe result not stored");

  // Bus answer; a frozen cycle may hold ack, so only a running edge drops it
  a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack held over two cycles");

  // ----------------------------------------------------------
  // Further checks
  // ----------------------------------------------------------
  // Attribute half of the probe result, for the checks below
  wire bao_attr_t probe_attr = 16'(xlat_result);

  // Every request at a running edge gets its answer on the next edge
  a_ack_follows: assert property (ce_i && wb_req |=> wb_ack_o)
    else $error("request not acknowledged");

  // Low enable must hold the valid, ack, path and beat count where they were
  a_ce_freeze: assert property (!ce_i |=> $stable(out_valid_o) && $stable(txn_count)
    && $stable(wb_ack_o) && $stable(out_path_o))
    else $error("state moved while enable low");

  // Unconfigured entries end as aborts
  a_abort_flag: assert property (ce_i && in_valid_i && txn_path == PATH_ABORT |=> out_rsp_o.abort)
    else $error("abort path without abort flag");

  // Bypass config wins over translation once the side is enabled
  a_ste_path: assert property (ce_i && in_valid_i && txn_ste[F_CFG +: 3] == CFG_BYPASS
    && (txn_sec ? secure_control_reg : nonsecure_control_reg) |=> out_path_o == PATH_STE_BYP)
    else $error("bypass entry not taken");

  // Secure global bypass takes the forced security value
  a_sgbp_ns_field: assert property (ce_i && in_valid_i && txn_path == PATH_S_GBP
    && secure_bypass_attr_reg[F_NS + 1] |=> out_rsp_o.attr.ns == $past(secure_bypass_attr_reg[F_NS]))
    else $error("secure bypass security field ignored");

  // An unsupplied type with no override comes out Normal write-back
  a_default_mt: assert property (ce_i && in_valid_i && !in_req_i.supplied[SUP_MT]
    && txn_path == PATH_NS_GBP && !nonsecure_bypass_attr_reg[F_MEMORY_TYPE_OVERRIDE_SEL] |=> out_rsp_o.attr.mt == MT_NORMAL_WB)
    else $error("default memory type not used");

  // Outer level twin of the inner hint clean-up
  a_nc_outer_hints: assert property (out_valid_o && (!out_rsp_o.attr.mt[4]
    || out_rsp_o.attr.mt[3:2] == C_NC) |-> !(out_rsp_o.attr.o_ra | out_rsp_o.attr.o_wa | out_rsp_o.attr.o_tr))
    else $error("hints on non-cacheable outer level");

  // Inner level twin of the transient clean-up
  a_noalloc_intr: assert property (out_valid_o && out_rsp_o.attr.mt[4]
    && !out_rsp_o.attr.i_ra && !out_rsp_o.attr.i_wa |-> !out_rsp_o.attr.i_tr)
    else $error("transient on no-allocate inner level");

  // Probe result obeys the same clean-up as live beats
  a_probe_osh: assert property (xlat_result[F_XVLD] && !cacheable(probe_attr.mt)
    |-> probe_attr.sh == SH_OSH)
    else $error("probe result shareability inconsistent");

endmodule : bao_top

// ===== dv/bao_client_model.sv
// Client bus master model that issues transaction beats and collects the answer
`timescale 1ns/10ps
module bao_client_model (
  input wire logic clk_i,
  output bao_pkg::bao_req_t in_req_o,
  output logic in_valid_o,
  input wire logic out_valid_i,
  input wire bao_pkg::bao_rsp_t out_rsp_i,
  input wire bao_pkg::bao_path_t out_path_i
);
  import bao_pkg::*;

  // Idle at time zero
  initial begin
    in_valid_o = 1'b0;
    in_req_o = '0;
  end

  // One beat: drive after an edge, taken at the next, answer sampled one cycle later
  // Released lines carry the inverse of the beat so a stale value never passes for a fresh one
  task automatic send(input bao_req_t r, output bao_rsp_t rsp, output bao_path_t path, output logic seen);
    @(posedge clk_i);
    in_valid_o <= 1'b1;
    in_req_o <= r;
    @(posedge clk_i);
    in_valid_o <= 1'b0;
    in_req_o <= ~r;
    @(posedge clk_i);
    seen = out_valid_i;
    rsp = out_rsp_i;
    path = out_path_i;
  endtask : send
endmodule : bao_client_model

// ===== dv/bao_tb_top.sv
// Self-checking testbench of the bypass attribute override block
`timescale 1ns/10ps
module bao_tb_top;
  import bao_pkg::*;

  function automatic bao_attr_t att(input logic [4:0] mt, input logic [1:0] sh, input logic [5:0] h,
                                    input logic [2:0] ipn);
    return bao_attr_t'({mt, sh, h, ipn});
  endfunction : att

  // Limit well above the roughly 120 cycles the sequence needs
  localparam int LIMIT = 4000;
  localparam bao_attr_t DFL = att(5'h1f, SH_NSH, 6'b110110, 3'b001);
  localparam bao_attr_t DFL_S = att(5'h1f, SH_NSH, 6'b110110, 3'b000);
  localparam bao_attr_t FWB = att(5'h1f, SH_ISH, 6'b110110, 3'b001);
  localparam bao_attr_t NOFWB = att(5'h12, SH_ISH, 6'b110000, 3'b001);
  logic clk_i, sys_rst_i, ce_i, wb_cyc, wb_stb, wb_we, wb_ack, in_valid, out_valid;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_wdat, wb_rdat, d;
  bao_req_t in_req;
  bao_rsp_t out_rsp;
  bao_path_t out_path;
  bao_rsp_t frz_rsp;
  bao_path_t frz_path;
  logic frz_seen;
  int n_fail = 0;
  int total_checks = 0;
  int n_beats = 0;
  int cycles = 0;

  bao_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .in_valid_i(in_valid), .in_req_i(in_req), .out_valid_o(out_valid),
    .out_rsp_o(out_rsp), .out_path_o(out_path));
  bao_client_model i_client (.clk_i(clk_i), .in_req_o(in_req), .in_valid_o(in_valid),
    .out_valid_i(out_valid), .out_rsp_i(out_rsp), .out_path_i(out_path));

  // ----------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // A hang counts as a mismatch and closes the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ----------------------------------------------------------
  // Register bus and beat tasks
  // ----------------------------------------------------------
  // Classic cycle held until ack is sampled high, released at that same edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hf;
    wb_wdat <= wd;
    @(posedge clk_i);
    while (wb_ack !== 1'b1) @(posedge clk_i);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb_xfer

  task automatic wb_write(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] junk;
    wb_xfer(1'b1, adr, wd, junk);
  endtask : wb_write

  // One read beat through the client model, every output field compared
  task automatic beat(input logic [3:0] sid, input logic sec, input logic nsnp, input logic [5:0] sup,
                      input bao_attr_t ain, input bao_attr_t exp, input bao_path_t ep);
    bao_req_t r;
    bao_rsp_t rsp;
    bao_path_t p;
    logic seen;
    r.addr = 32'h4000_0000 + 32'(n_beats * 16);
    r.we = 1'b0;
    r.data = ~r.addr;
    r.stream_identifier = sid;
    r.secure_stream_flag = sec;
    r.no_snoop = nsnp;
    r.supplied = sup;
    r.attr = ain;
    i_client.send(r, rsp, p, seen);
    n_beats++;
    check(32'(seen), 32'h1);
    check(rsp.addr, r.addr);
    check(rsp.data, r.data);
    check(32'(rsp.we), 32'h0);
    check(32'(rsp.abort), 32'(ep == PATH_ABORT));
    check(32'(rsp.attr), 32'(exp));
    check(32'(p), 32'(ep));
  endtask : beat

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    // Reset values, read-only capability bits, an unmapped place
    wb_xfer(1'b0, 8'h08, 32'h0, d);
    check(d, NS_BYP_RST);
    wb_xfer(1'b0, 8'h0c, 32'h0, d);
    check(d, S_BYP_RST);
    wb_write(8'h10, 32'h0);
    wb_xfer(1'b0, 8'h10, 32'h0, d);
    check(32'(d[8]), 32'h1);
    wb_xfer(1'b0, 8'h14, 32'h0, d);
    check(32'(d[31]), 32'h1);
    wb_xfer(1'b0, 8'h40, 32'h0, d);
    check(d, 32'h0);
    // Global bypass with use-incoming fields and consistency fixes
    beat(4'h1, 1'b0, 1'b0, 6'h00, 16'h0000, DFL, PATH_NS_GBP);
    beat(4'h1, 1'b0, 1'b0, 6'h3f, att(5'h1f, SH_ISH, 6'b001001, 3'b010),
         att(5'h1f, SH_ISH, 6'b000000, 3'b011), PATH_NS_GBP);
    beat(4'h1, 1'b0, 1'b0, 6'h3f, att(5'h1c, SH_NSH, 6'b111111, 3'b000),
         att(5'h1c, SH_NSH, 6'b000111, 3'b001), PATH_NS_GBP);
    beat(4'h1, 1'b0, 1'b0, 6'h3f, att(5'h10, SH_NSH, 6'b111111, 3'b000),
         att(5'h10, SH_OSH, 6'b000000, 3'b001), PATH_NS_GBP);
    beat(4'h1, 1'b0, 1'b0, 6'h3f, att(5'h01, SH_ISH, 6'b111111, 3'b000),
         att(5'h01, SH_OSH, 6'b000000, 3'b001), PATH_NS_GBP);
    // Every override field forced; the security field cannot clear the output flag
    wb_write(8'h08, 32'h002f_3d21);
    beat(4'h1, 1'b0, 1'b0, 6'h00, DFL, att(5'h01, SH_OSH, 6'b000000, 3'b111), PATH_NS_GBP);
    // Secure global bypass follows its own security field
    wb_write(8'h0c, 32'h0020_0000);
    beat(4'h0, 1'b1, 1'b0, 6'h00, DFL, DFL_S, PATH_S_GBP);
    wb_write(8'h0c, 32'h0000_1000);
    beat(4'h0, 1'b1, 1'b0, 6'h20, DFL_S, DFL_S, PATH_S_GBP);
    // Secure side enabled only: a non-secure stream still takes its global bypass
    wb_write(8'h04, 32'h1);
    beat(4'h3, 1'b0, 1'b0, 6'h00, DFL, att(5'h01, SH_OSH, 6'b000000, 3'b111), PATH_NS_GBP);
    wb_write(8'h00, 32'h1);
    // Entry bypass: global register ignored, entry overrides applied
    wb_write(8'h8c, 32'h0428_0030);
    beat(4'h3, 1'b0, 1'b0, 6'h10, att(5'h1f, SH_NSH, 6'b110110, 3'b010),
         att(5'h10, SH_OSH, 6'b000000, 3'b001), PATH_STE_BYP);
    wb_write(8'hc8, 32'h0420_0000);
    beat(4'h2, 1'b1, 1'b0, 6'h00, DFL, DFL_S, PATH_STE_BYP);
    beat(4'h7, 1'b0, 1'b0, 6'h00, DFL, DFL, PATH_ABORT);
    // Forced write-back, then a no-snoop beat that must escape it
    wb_write(8'h94, 32'h1600_3e32);
    beat(4'h5, 1'b0, 1'b0, 6'h00, DFL, FWB, PATH_XLAT);
    beat(4'h5, 1'b0, 1'b1, 6'h00, DFL, NOFWB, PATH_XLAT);
    // Software translation probe reports the forced and corrected attributes
    wb_write(8'h1c, 32'h0000_0005);
    wb_xfer(1'b0, 8'h20, 32'h0, d);
    check(d, {1'b1, 4'h0, PATH_XLAT, 8'h00, FWB});
    // Probe of the entry-bypass stream: non-cacheable type cleaned up
    wb_write(8'h1c, 32'h0000_0003);
    wb_xfer(1'b0, 8'h20, 32'h0, d);
    check(d, {1'b1, 4'h0, PATH_STE_BYP, 8'h00, att(5'h10, SH_OSH, 6'h00, 3'b001)});
    wb_write(8'h94, 32'h0600_3e32);
    beat(4'h5, 1'b0, 1'b0, 6'h00, DFL, NOFWB, PATH_XLAT);
    // Enable low: a beat offered meanwhile is not taken and the outputs hold
    @(posedge clk_i);
    ce_i <= 1'b0;
    i_client.send('0, frz_rsp, frz_path, frz_seen);
    ce_i <= 1'b1;
    check(32'(frz_seen), 32'h0);
    check(32'(frz_path), 32'(PATH_XLAT));
    check(32'(frz_rsp.attr), 32'(NOFWB));
    // Status holds the last path and the beat count
    wb_xfer(1'b0, 8'h18, 32'h0, d);
    check(32'(d[18:16]), 32'(PATH_XLAT));
    check(32'(d[15:0]), 32'(n_beats));
    give_verdict();
  end
endmodule : bao_tb_top
